//--- rjt_pkg.sv
package rjt_pkg;
   localparam logic [11:0] RJT_OFF_CNT = 12'h110;
   localparam logic [11:0] RJT_OFF_CTRL = 12'h112;
   localparam logic [11:0] RJT_OFF_IOC = 12'h113;
   localparam logic [11:0] RJT_OFF_MODE = 12'h114;
   localparam logic [11:0] RJT_OFF_CSRC = 12'h118;
   localparam logic [15:0] RJT_CNT_RST = 16'hffff;
   localparam logic [7:0] RJT_IOC_RST = 8'h00;
   localparam logic [7:0] RJT_MODE_RST = 8'h00;
   localparam logic [7:0] RJT_CSRC_RST = 8'h00;
   localparam int RJT_B_RUN = 0;
   localparam int RJT_B_ACT = 1;
   localparam int RJT_B_HALT = 2;
   localparam int RJT_B_EDGF = 4;
   localparam int RJT_B_WRAP = 5;
   localparam int RJT_B_POL = 0;
   localparam int RJT_B_TPD = 1;
   localparam int RJT_B_OE2 = 2;
   localparam int RJT_B_ESRC = 3;
   localparam int RJT_B_FLT = 4;
   localparam int RJT_B_GATE = 6;
   localparam logic [2:0] RJT_M_TIMER = 3'h0;
   localparam logic [2:0] RJT_M_PULSE = 3'h1;
   localparam logic [2:0] RJT_M_EVENT = 3'h2;
   localparam logic [2:0] RJT_M_WIDTH = 3'h3;
   localparam logic [2:0] RJT_M_PERIOD = 3'h4;
   localparam logic [5:0] RJT_DIV8 = 6'h07;
   localparam logic [5:0] RJT_DIV32 = 6'h1f;
   localparam logic [1:0] RJT_FLT_SAMPLES = 2'h3;
endpackage

//--- rjt_sync.sv
`timescale 1ns/1ps
module rjt_sync
   import rjt_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // level crossing
   input wire logic d_in,
   output logic q_out
);
   logic meta_r;
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         meta_r <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule

//--- rjt_filter.sv
`timescale 1ns/1ps
module rjt_filter
   import rjt_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // control
   input wire logic [1:0] rate_in,
   input wire logic d_in,
   output logic q_out
);
   logic [5:0] div_r;
   logic [1:0] same_r;
   logic last_r;
   logic tick;
   // ---------------------------------------------
   // sample rate
   // ---------------------------------------------
   always_comb begin
      case (rate_in)
         2'h1: tick = 1'b1;
         2'h2: tick = (div_r[2:0] == RJT_DIV8[2:0]);
         2'h3: tick = (div_r == RJT_DIV32);
         default: tick = 1'b0;
      endcase
   end
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         div_r <= 6'h00;
      end else begin
         div_r <= div_r + 6'h01;
      end
   end
   // ---------------------------------------------
   // three matching samples
   // ---------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         last_r <= 1'b0;
         same_r <= 2'h0;
         q_out <= 1'b0;
      end else if (rate_in == 2'h0) begin
         q_out <= d_in;
         last_r <= d_in;
         same_r <= 2'h0;
      end else if (tick) begin
         last_r <= d_in;
         if (d_in != last_r) begin
            same_r <= 2'h1;
         end else if (same_r != RJT_FLT_SAMPLES) begin
            same_r <= same_r + 2'h1;
            if (same_r + 2'h1 == RJT_FLT_SAMPLES) begin
               q_out <= d_in;
            end
         end
      end
   end
endmodule

//--- rjt_timer.sv
`timescale 1ns/1ps
module rjt_timer
   import rjt_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer pins
   input wire logic timer_io_pin_in,
   output logic timer_io_pin_out,
   output logic timer_io_pin_oe_out,
   output logic timer_out_pin_out,
   output logic timer_out_pin_oe_out,
   input wire logic gate_input_pin_in,
   // neighbouring logic
   input wire logic lin_event_in,
   input wire logic other_timer_period_in,
   input wire logic count_tick_in
);
   logic [15:0] cnt_r;
   logic [15:0] reload_r;
   logic run_r;
   logic act_r;
   logic edgf_r;
   logic wrap_r;
   logic [7:0] ioc_r;
   logic [7:0] mode_r;
   logic [7:0] csrc_r;
   logic out_r;
   logic io_s;
   logic gate_s;
   logic flt;
   logic ev_src;
   logic ev_d_r;
   logic wr;
   logic rd_ok;
   logic halt;
   logic [2:0] opmode;
   logic pol;
   logic src_tick;
   logic rise;
   logic fall;
   logic act_edge;
   logic gate_ok;
   logic dec;
   logic wrap_ev;
   logic edge_ev;
   logic [7:0] ctrl_rd;
   logic sel_cnt;
   logic sel_ctrl;
   logic sel_ioc;
   logic sel_mode;
   logic sel_csrc;

   // each register owns one aligned word, so its byte address is four times its offset
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
      return a == {off[9:0], 2'b00};
   endfunction

   // ---------------------------------------------
   // input capture
   // ---------------------------------------------
   rjt_sync u_sync_io (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .d_in(timer_io_pin_in),
      .q_out(io_s)
   );
   rjt_sync u_sync_gate (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .d_in(gate_input_pin_in),
      .q_out(gate_s)
   );
   rjt_filter u_filter (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .rate_in(ioc_r[RJT_B_FLT +: 2]),
      .d_in(io_s),
      .q_out(flt)
   );

   // ---------------------------------------------
   // bus decode
   // ---------------------------------------------
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign opmode = mode_r[2:0];
   assign pol = ioc_r[RJT_B_POL];
   assign sel_cnt = reg_hit(paddr, RJT_OFF_CNT);
   assign sel_ctrl = reg_hit(paddr, RJT_OFF_CTRL);
   assign sel_ioc = reg_hit(paddr, RJT_OFF_IOC);
   assign sel_mode = reg_hit(paddr, RJT_OFF_MODE);
   assign sel_csrc = reg_hit(paddr, RJT_OFF_CSRC);
   assign halt = wr && sel_ctrl && pwdata[RJT_B_HALT];
   assign rd_ok = sel_cnt || sel_ctrl || sel_ioc || sel_mode || sel_csrc;
   assign pslverr = psel && penable && !rd_ok;
   // halt bit and bits 3, 6, 7 read zero
   assign ctrl_rd = {2'b00, wrap_r, edgf_r, 2'b00, act_r, run_r};

   // ---------------------------------------------
   // event source, edge and gate
   // ---------------------------------------------
   // lin input is internal and already on this clock, so it bypasses the filter
   assign ev_src = ioc_r[RJT_B_ESRC] ? lin_event_in : flt;
   assign rise = ev_src && !ev_d_r;
   assign fall = !ev_src && ev_d_r;
   // event mode: pol 0 rising, 1 falling; period mode the same edge choice
   assign act_edge = pol ? fall : rise;
   always_comb begin
      if (opmode == RJT_M_EVENT) begin
         case (ioc_r[RJT_B_GATE +: 2])
            2'h0: gate_ok = 1'b1;
            2'h1: gate_ok = gate_s;
            2'h2: gate_ok = other_timer_period_in;
            default: gate_ok = 1'b0;
         endcase
      end else begin
         gate_ok = 1'b1;
      end
   end
   // count source: external edge in event mode, count_tick_in in timer, pulse, width and period modes
   always_comb begin
      case (opmode)
         RJT_M_EVENT: src_tick = act_edge && gate_ok;
         // width mode counts only while the input sits at the measured level
         RJT_M_WIDTH: src_tick = count_tick_in && (ev_src == pol);
         RJT_M_TIMER, RJT_M_PULSE, RJT_M_PERIOD: src_tick = count_tick_in;
         default: src_tick = 1'b0;
      endcase
   end
   always_comb begin
      case (opmode)
         RJT_M_WIDTH: edge_ev = act_r && (pol ? fall : rise);
         RJT_M_PERIOD: edge_ev = act_r && act_edge;
         default: edge_ev = 1'b0;
      endcase
   end
   assign dec = act_r && src_tick;
   assign wrap_ev = dec && (cnt_r == 16'h0000);
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         ev_d_r <= 1'b0;
      end else begin
         ev_d_r <= ev_src;
      end
   end

   // ---------------------------------------------
   // run control
   // ---------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         run_r <= 1'b0;
      end else if (halt) begin
         run_r <= 1'b0;
      end else if (wr && sel_ctrl) begin
         run_r <= pwdata[RJT_B_RUN];
      end
   end
   // status follows the request on a count_tick_in pulse, or on every clock in event mode
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         act_r <= 1'b0;
      end else if (halt) begin
         act_r <= 1'b0;
      end else if (count_tick_in || (opmode == RJT_M_EVENT)) begin
         act_r <= run_r;
      end
   end

   // ---------------------------------------------
   // flags: a set in the clearing cycle wins
   // ---------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         edgf_r <= 1'b0;
         wrap_r <= 1'b0;
      end else begin
         if (edge_ev) begin
            edgf_r <= 1'b1;
         end else if (wr && sel_ctrl && !pwdata[RJT_B_EDGF]) begin
            edgf_r <= 1'b0;
         end
         if (wrap_ev) begin
            wrap_r <= 1'b1;
         end else if (wr && sel_ctrl && !pwdata[RJT_B_WRAP]) begin
            wrap_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // reload and counter
   // ---------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         reload_r <= RJT_CNT_RST;
      end else if (wr && sel_cnt) begin
         reload_r <= pwdata[15:0];
      end
   end
   // a stopped counter tracks reload so a start begins from the new value
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         cnt_r <= RJT_CNT_RST;
      end else if (halt) begin
         cnt_r <= RJT_CNT_RST;
      end else if (wr && sel_cnt && !act_r) begin
         cnt_r <= pwdata[15:0];
      end else if (wrap_ev) begin
         cnt_r <= reload_r;
      end else if (dec) begin
         cnt_r <= cnt_r - 16'h0001;
      end else if (edge_ev) begin
         cnt_r <= reload_r;
      end
   end

   // ---------------------------------------------
   // configuration registers
   // ---------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         ioc_r <= RJT_IOC_RST;
         mode_r <= RJT_MODE_RST;
         csrc_r <= RJT_CSRC_RST;
      end else if (wr) begin
         if (sel_ioc) begin
            ioc_r <= pwdata[7:0];
         end
         if (sel_mode) begin
            mode_r <= pwdata[7:0];
         end
         if (sel_csrc) begin
            csrc_r <= pwdata[7:0];
         end
      end
   end

   // ---------------------------------------------
   // pulse output
   // ---------------------------------------------
   // io pin starts high at pol 0; the dedicated pin uses the opposite sense
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         out_r <= 1'b1;
      end else if (halt || (wr && sel_mode)) begin
         out_r <= !pol;
      end else if (wr && sel_ioc) begin
         out_r <= !pwdata[RJT_B_POL];
      end else if (wrap_ev && opmode == RJT_M_PULSE) begin
         out_r <= !out_r;
      end
   end
   assign timer_io_pin_out = out_r;
   assign timer_io_pin_oe_out = (opmode == RJT_M_PULSE) && !ioc_r[RJT_B_TPD];
   assign timer_out_pin_out = !out_r;
   assign timer_out_pin_oe_out = ioc_r[RJT_B_OE2];

   // ---------------------------------------------
   // read data
   // ---------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (1'b1)
            sel_cnt: prdata <= {16'h0000, cnt_r};
            sel_ctrl: prdata <= {24'h000000, ctrl_rd};
            sel_ioc: prdata <= {24'h000000, ioc_r};
            sel_mode: prdata <= {24'h000000, mode_r};
            sel_csrc: prdata <= {24'h000000, csrc_r};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

//--- rjt_timer_properties.sv
`timescale 1ns/1ps
module rjt_timer_properties
   import rjt_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // pins
   input wire logic timer_io_pin_out,
   input wire logic timer_io_pin_oe_out,
   input wire logic timer_out_pin_out,
   input wire logic timer_out_pin_oe_out,
   input wire logic count_tick_in
);
   // byte addresses: one aligned word per register offset
   localparam logic [11:0] A_CNT = {RJT_OFF_CNT[9:0], 2'b00};
   localparam logic [11:0] A_CTRL = {RJT_OFF_CTRL[9:0], 2'b00};
   localparam logic [11:0] A_IOC = {RJT_OFF_IOC[9:0], 2'b00};
   localparam logic [11:0] A_MODE = {RJT_OFF_MODE[9:0], 2'b00};
   localparam logic [11:0] A_CSRC = {RJT_OFF_CSRC[9:0], 2'b00};
   logic acc, wr_acc, rd_ctl, mapped;
   logic [7:0] ioc_r;
   logic [2:0] mode_r;
   assign acc = psel && penable;
   assign wr_acc = acc && pwrite;
   assign rd_ctl = acc && !pwrite && paddr == A_CTRL;
   assign mapped = paddr inside {A_CNT, A_CTRL, A_IOC, A_MODE, A_CSRC};
   // shadow copies, so pin enables can be judged without peeking inside
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) ioc_r <= 8'h00;
      else if (wr_acc && paddr == A_IOC) ioc_r <= pwdata[7:0];
   end
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) mode_r <= 3'h0;
      else if (wr_acc && paddr == A_MODE) mode_r <= pwdata[2:0];
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   a_ctrl_reserved_zero: assert property (rd_ctl |-> !prdata[3] && !prdata[6])
      else $error("control spare bits not zero");
   a_halt_reads_zero: assert property (rd_ctl |-> !prdata[RJT_B_HALT])
      else $error("halt bit read as one");
   a_io_oe_mode: assert property (timer_io_pin_oe_out ==
      (mode_r == RJT_M_PULSE && !ioc_r[RJT_B_TPD])) else $error("io pin enable wrong");
   a_out_oe_bit: assert property (timer_out_pin_oe_out == ioc_r[RJT_B_OE2])
      else $error("out pin enable wrong");
   a_halt_out_init: assert property (wr_acc && paddr == A_CTRL &&
      pwdata[RJT_B_HALT] && mode_r == RJT_M_PULSE |=> timer_io_pin_out == !ioc_r[RJT_B_POL])
      else $error("halt left output level");
   a_out_pin_inverse: assert property (timer_out_pin_out == !timer_io_pin_out)
      else $error("out pin not inverse");
   a_toggle_on_tick: assert property ($changed(timer_io_pin_out) |->
      $past(count_tick_in) || $past(wr_acc)) else $error("output moved without cause");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("no error for unmapped address");
   a_mapped_ok: assert property (acc && mapped |-> !pslverr)
      else $error("error on mapped address");
   a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   c_halt: cover property (wr_acc && paddr == A_CTRL && pwdata[RJT_B_HALT]);
   c_toggle: cover property ($changed(timer_io_pin_out));
   c_unmapped: cover property (acc && !mapped);
endmodule
bind rjt_timer rjt_timer_properties chk (.mclk_in, .nrst_in, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pslverr, .timer_io_pin_out, .timer_io_pin_oe_out,
   .timer_out_pin_out, .timer_out_pin_oe_out, .count_tick_in);

//--- rjt_pin_model.sv
`timescale 1ns/1ps
module rjt_pin_model (
   // clock
   input wire logic mclk_in,
   // bench commands
   input wire logic lvl_in,
   input wire logic glitch_in,
   // pin side
   output logic pin_out
);
   logic pin_r = 1'b0;
   // glitch flips every cycle so no three samples agree
   always @(posedge mclk_in) begin
      pin_r <= glitch_in ? !pin_r : lvl_in;
   end
   assign pin_out = pin_r;
endmodule

//--- reload_timer_control_io_tb_top.sv
`timescale 1ns/1ps
module reload_timer_control_io_tb_top
   import rjt_pkg::*;
;
   // one aligned word per register: byte address is four times the offset
   localparam logic [11:0] CN = {RJT_OFF_CNT[9:0], 2'b00};
   localparam logic [11:0] CT = {RJT_OFF_CTRL[9:0], 2'b00};
   localparam logic [11:0] IO = {RJT_OFF_IOC[9:0], 2'b00};
   localparam logic [11:0] MD = {RJT_OFF_MODE[9:0], 2'b00};
   logic mclk_in = 1'b0, nrst_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, io_out, io_oe, out_pin, out_oe, io_wire, pin, last_err;
   logic gate = 1'b0, lin = 1'b0, tick = 1'b0, lvl = 1'b0, glitch = 1'b0, oth = 1'b0;
   int err_count = 0, comparisons = 0, cyc = 0;
   // pin released by the timer is driven by the far side
   assign io_wire = io_oe ? io_out : pin;
   initial forever #50 mclk_in = ~mclk_in;
   rjt_timer uut (.mclk_in, .nrst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .timer_io_pin_in(io_wire), .timer_io_pin_out(io_out),
      .timer_io_pin_oe_out(io_oe), .timer_out_pin_out(out_pin), .timer_out_pin_oe_out(out_oe),
      .gate_input_pin_in(gate), .lin_event_in(lin), .other_timer_period_in(oth),
      .count_tick_in(tick));
   rjt_pin_model pins (.mclk_in, .lvl_in(lvl), .glitch_in(glitch), .pin_out(pin));
   // ----------------
   // tasks
   // ----------------
   task results;
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_in);
      penable <= 1'b1;
      do @(posedge mclk_in); while (pready !== 1'b1);
      last_err = pslverr;
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task ticks(input int n);
      repeat (n) begin
         @(posedge mclk_in);
         tick <= 1'b1;
         @(posedge mclk_in);
         tick <= 1'b0;
      end
   endtask
   task pulse(input logic on_lin);
      repeat (3) @(posedge mclk_in);
      if (on_lin) lin <= 1'b1;
      else lvl <= 1'b1;
      repeat (6) @(posedge mclk_in);
      lin <= 1'b0;
      lvl <= 1'b0;
      repeat (6) @(posedge mclk_in);
   endtask
   // hang guard, far above the roughly 400 cycles used
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 8000) begin
         err_count++;
         results;
      end
   end
   initial begin
      repeat (16) @(posedge mclk_in);
      nrst_in <= 1'b1;
      rd(CN, 32'hffff);
      rd(IO, 32'h0);
      rd(CT, 32'h0);
      rd(12'h11c, 32'h0);
      chk(last_err, 1'b1);
      wr(IO, 32'h40);
      wr(CN, 32'h3);
      rd(CN, 32'h3);
      wr(CT, 32'h1);
      ticks(1);
      rd(CT, 32'h3);
      wr(CN, 32'h2);
      rd(CN, 32'h3);
      ticks(3);
      rd(CN, 32'h0);
      ticks(1);
      rd(CN, 32'h2);
      rd(CT, 32'h23);
      wr(CT, 32'h21);
      rd(CT, 32'h23);
      wr(CT, 32'h1);
      rd(CT, 32'h3);
      wr(CT, 32'h0);
      rd(CT, 32'h2);
      ticks(1);
      rd(CT, 32'h0);
      wr(CT, 32'h4);
      wr(MD, 32'h1);
      wr(IO, 32'h0);
      wr(CN, 32'h1);
      @(negedge mclk_in);
      chk(io_oe, 1'b1);
      wr(CT, 32'h1);
      ticks(3);
      @(negedge mclk_in);
      chk(io_out, 1'b0);
      chk(out_pin, 1'b1);
      wr(CT, 32'h4);
      rd(CT, 32'h0);
      rd(CN, 32'hffff);
      chk(io_out, 1'b1);
      wr(IO, 32'h6);
      @(negedge mclk_in);
      chk(io_oe, 1'b0);
      chk(out_oe, 1'b1);
      rd(IO, 32'h6);
      wr(MD, 32'h2);
      wr(IO, 32'h40);
      wr(CN, 32'h10);
      wr(CT, 32'h1);
      pulse(1'b0);
      pulse(1'b0);
      rd(CN, 32'h10);
      gate <= 1'b1;
      pulse(1'b0);
      pulse(1'b0);
      rd(CN, 32'he);
      wr(IO, 32'h48);
      pulse(1'b0);
      pulse(1'b1);
      rd(CN, 32'hd);
      wr(IO, 32'h80);
      pulse(1'b0);
      oth <= 1'b1;
      pulse(1'b0);
      rd(CN, 32'hc);
      wr(IO, 32'h50);
      glitch <= 1'b1;
      repeat (12) @(posedge mclk_in);
      glitch <= 1'b0;
      pulse(1'b0);
      rd(CN, 32'hb);
      // width mode then period mode: a rising edge ends the measurement
      for (logic [31:0] m = 32'h3; m <= 32'h4; m++) begin
         wr(CT, 32'h4);
         wr(MD, m);
         wr(IO, 32'h0);
         wr(CN, 32'h20);
         wr(CT, 32'h1);
         ticks(3);
         rd(CN, 32'h1e);
         pulse(1'b0);
         rd(CN, 32'h20);
         rd(CT, 32'h13);
         wr(CT, 32'h1);
         rd(CT, 32'h3);
      end
      results;
   end
endmodule
